// file: include/front_filter_pkg.sv
// Purpose: Shared constants for the CSI video pipe front filter.
// Assumes: AXI4-Lite register access, 32-bit data, byte-wide registers in the low bits.
// Notes:   Printed offsets are not all word aligned, so they are kept as indices.
`default_nettype none
package front_filter_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned VC_W = 4;
   localparam int unsigned NUM_VC = 16;
   localparam int unsigned DT_W = 6;
   localparam int unsigned WC_W = 16;

   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_FRONT_PIPE_CONTROL  = 10'h308;
   localparam logic [9:0] IDX_VC_FILTER_LOW_BYTE  = 10'h30D;
   localparam logic [9:0] IDX_VC_FILTER_HIGH_BYTE = 10'h30E;
   localparam logic [9:0] IDX_PIPE_LAUNCH_CONTROL = 10'h311;
   localparam logic [9:0] IDX_PIPE_STATUS         = 10'h320;

   // Field positions
   localparam int unsigned BIT_LINE_INFO   = 6;
   localparam int unsigned BIT_CSI_ON      = 5;
   localparam int unsigned BIT_PIPE_LAUNCH = 6;

   // Writable masks and reset values
   localparam logic [7:0] CTRL_WMASK   = 8'h60;
   localparam logic [7:0] CTRL_RESET   = 8'h64;
   localparam logic [7:0] FILT_WMASK   = 8'hFF;
   localparam logic [7:0] FILT_RESET   = 8'hFF;
   localparam logic [7:0] LAUNCH_WMASK = 8'h40;
   localparam logic [7:0] LAUNCH_RESET = 8'h40;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: tb/csi_sensor_model.sv
// Purpose: Camera sensor stand-in presenting parsed packet headers.
// Assumes: Headers change just after a rising edge.
// Notes:   Idle lines show inverted values so stale data never looks fresh.
`default_nettype none
module csi_sensor_model (
   input  wire logic       clk,
   output logic            pkt_hdr_valid,
   output logic [3:0]      pkt_hdr_vc,
   output logic            pkt_line_start
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      pkt_hdr_valid = 1'b0;
      pkt_hdr_vc = 4'h0;
      pkt_line_start = 1'b0;
   end
   // All sixteen channels back to back in a scrambled order
   task automatic burst(input logic [3:0] scramble, input logic [15:0] ls);
      for (int i = 0; i < 16; i++) begin
         pkt_hdr_valid <= 1'b1;
         pkt_hdr_vc <= i[3:0] ^ scramble;
         pkt_line_start <= ls[i];
         @(posedge clk);
      end
      pkt_hdr_valid <= 1'b0;
      pkt_hdr_vc <= ~pkt_hdr_vc;
      pkt_line_start <= ~pkt_line_start;
   endtask
endmodule
`default_nettype wire

// file: tb/csi_video_pipe_front_filter_tb_top.sv
// Purpose: Self-checking bench for the video pipe front filter.
// Assumes: bready and rready stay high, so every answer is taken at once.
// Notes:   A register model predicts every verdict and readback.
`default_nettype none
module csi_video_pipe_front_filter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] A_CTRL = {front_filter_pkg::IDX_FRONT_PIPE_CONTROL, 2'b00};
   localparam logic [11:0] A_FLO = {front_filter_pkg::IDX_VC_FILTER_LOW_BYTE, 2'b00};
   localparam logic [11:0] A_FHI = {front_filter_pkg::IDX_VC_FILTER_HIGH_BYTE, 2'b00};
   localparam logic [11:0] A_LAUNCH = {front_filter_pkg::IDX_PIPE_LAUNCH_CONTROL, 2'b00};
   localparam logic [11:0] A_NONE = 12'hC00;
   localparam logic [11:0] A_STAT = {front_filter_pkg::IDX_PIPE_STATUS, 2'b00};
   logic        clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, pkt_hdr_vc;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        pkt_hdr_valid, pkt_line_start, csi_input_on, line_info_on, pipe_launch_from_csi;
   logic        line_info_insert, pkt_pass, pkt_drop, e_live, e_pass1, e_drop1, e_pass2, e_drop2, e_ins1;
   logic [7:0]  m_ctrl, m_flo, m_fhi, m_launch;
   logic [15:0] m_keep, m_np, m_nd;
   logic [11:0] addrs [6] = '{A_CTRL, A_FLO, A_FHI, A_LAUNCH, A_NONE, A_STAT};
   int          failures = 0;
   int          compares = 0;
   assign m_keep = {m_fhi, m_flo};
   csi_video_pipe_front_filter DUT (
      .clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .pkt_hdr_valid, .pkt_hdr_vc, .pkt_line_start, .csi_input_on, .line_info_on,
      .pipe_launch_from_csi, .line_info_insert, .pkt_pass, .pkt_drop);
   csi_sensor_model sensor (.clk, .pkt_hdr_valid, .pkt_hdr_vc, .pkt_line_start);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out();
      if (failures == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic logic [33:0] mdl_rd(input logic [11:0] a);
      case (a)
         A_CTRL: return {front_filter_pkg::RESP_OKAY, 24'h0, m_ctrl};
         A_FLO: return {front_filter_pkg::RESP_OKAY, 24'h0, m_flo};
         A_FHI: return {front_filter_pkg::RESP_OKAY, 24'h0, m_fhi};
         A_LAUNCH: return {front_filter_pkg::RESP_OKAY, 24'h0, m_launch};
         A_STAT: return {front_filter_pkg::RESP_OKAY, m_nd, m_np};
         default: return {front_filter_pkg::RESP_SLVERR, 32'h0};
      endcase
   endfunction
   task automatic reg_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
      logic [33:0] e;
      int n;
      e = mdl_rd(a);
      s_axi_awaddr <= a;
      s_axi_wdata <= ($urandom() << 8) | d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      check("bvalid", s_axi_bvalid, 32'h1);
      check("bresp", s_axi_bresp, e[33:32]);
      // Any write to the status word clears both counts, whatever the strobes
      if (a == A_STAT) {m_nd, m_np} = 32'h0;
      // Reserved bits keep their value; a cleared low strobe leaves the byte alone
      if (s[0] && a == A_CTRL) m_ctrl = d & front_filter_pkg::CTRL_WMASK | m_ctrl & ~front_filter_pkg::CTRL_WMASK;
      if (s[0] && a == A_LAUNCH) m_launch = d & front_filter_pkg::LAUNCH_WMASK | m_launch & ~front_filter_pkg::LAUNCH_WMASK;
      if (s[0] && a == A_FLO) m_flo = d;
      if (s[0] && a == A_FHI) m_fhi = d;
   endtask
   task automatic reg_rd(input logic [11:0] a);
      logic [33:0] e;
      int n;
      e = mdl_rd(a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      check("rvalid", s_axi_rvalid, 32'h1);
      check("rdata", s_axi_rdata, e[31:0]);
      check("rresp", s_axi_rresp, e[33:32]);
   endtask
   task automatic chk_outs();
      repeat (3) @(posedge clk);
      check("csi_input_on", csi_input_on, m_ctrl[5]);
      check("line_info_on", line_info_on, m_ctrl[6]);
      check("pipe_launch", pipe_launch_from_csi, m_launch[6]);
   endtask
   task automatic do_reset();
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      m_ctrl = front_filter_pkg::CTRL_RESET;
      m_flo = 8'hFF;
      m_fhi = 8'hFF;
      m_launch = front_filter_pkg::LAUNCH_RESET;
      m_np = 16'h0000;
      m_nd = 16'h0000;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      if (srst) begin
         {e_pass1, e_drop1, e_pass2, e_drop2, e_ins1} = 5'h00;
      end else begin
         check("pkt_pass", pkt_pass, e_pass2);
         check("pkt_drop", pkt_drop, e_drop2);
         check("line_info_insert", line_info_insert, e_ins1);
         if (e_pass2) m_np = m_np + 16'h0001;
         if (e_drop2) m_nd = m_nd + 16'h0001;
         e_pass2 = e_pass1;
         e_drop2 = e_drop1;
         e_live = pkt_hdr_valid && m_ctrl[5] && m_launch[6];
         e_pass1 = e_live && m_keep[pkt_hdr_vc];
         e_drop1 = e_live && !m_keep[pkt_hdr_vc];
         e_ins1 = e_pass1 && pkt_line_start && m_ctrl[6];
      end
   end
   initial begin
      #100000;
      failures++;
      close_out();
   end
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      void'($urandom(32'h6FDC58F5));
      do_reset();
      foreach (addrs[i]) reg_rd(addrs[i]);
      reg_wr(A_CTRL, 8'h9B, 4'hF);
      reg_rd(A_CTRL);
      reg_wr(A_NONE, 8'h00, 4'hF);
      for (int k = 0; k < 12; k++) begin
         reg_wr(A_CTRL, {1'b1, k[2], k[0] | k[3], 5'h1B}, 4'hF);
         reg_wr(A_LAUNCH, {1'b1, k[1] | k[3], 6'h2A}, 4'hF);
         reg_wr(A_FLO, 8'($urandom()), 4'($urandom()));
         reg_wr(A_FHI, 8'($urandom()), 4'($urandom()));
         reg_rd(A_LAUNCH);
         reg_rd(A_FHI);
         chk_outs();
         sensor.burst(4'($urandom()), 16'($urandom()));
         repeat (4) @(posedge clk);
         reg_rd(A_STAT);
         if (k[0]) reg_wr(A_STAT, 8'h00, 4'($urandom()));
      end
      do_reset();
      reg_rd(A_CTRL);
      reg_rd(A_FLO);
      chk_outs();
      sensor.burst(4'h5, 16'hFFFF);
      repeat (4) @(posedge clk);
      reg_rd(A_STAT);
      close_out();
   end
endmodule
`default_nettype wire

// file: tb/front_filter_asserts.sv
// Purpose: Port-level checks of the front filter.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Observes only; a stalled register never sets off these checks.
`default_nettype none
module front_filter_asserts (
   input wire logic clk,
   input wire logic srst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic pkt_hdr_valid,
   input wire logic pkt_line_start,
   input wire logic csi_input_on,
   input wire logic line_info_on,
   input wire logic pipe_launch_from_csi,
   input wire logic line_info_insert,
   input wire logic pkt_pass,
   input wire logic pkt_drop
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_hdr_live;
      pkt_hdr_valid && csi_input_on && pipe_launch_from_csi;
   endsequence
   sequence s_one_verdict;
      ##2 (pkt_pass ^ pkt_drop);
   endsequence
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_hdr_gets_verdict: assert property (s_hdr_live |-> s_one_verdict)
      else $error("header got no single verdict");
   a_pass_has_cause: assert property (pkt_pass |-> $past(pkt_hdr_valid, 2))
      else $error("pass pulse without header");
   a_drop_has_cause: assert property (pkt_drop |-> $past(pkt_hdr_valid, 2))
      else $error("drop pulse without header");
   a_port_off_quiet: assert property (pkt_hdr_valid && !csi_input_on |-> ##2 !(pkt_pass || pkt_drop))
      else $error("verdict while input port off");
   a_launch_off_quiet: assert property (pkt_hdr_valid && !pipe_launch_from_csi |-> ##2 !(pkt_pass || pkt_drop))
      else $error("verdict while pipe not started");
   a_insert_cause: assert property (line_info_insert |-> line_info_on && $past(pkt_hdr_valid && pkt_line_start))
      else $error("insert without enabled line start");
   a_insert_then_pass: assert property (line_info_insert |=> pkt_pass)
      else $error("insert for a dropped packet");
   a_reset_enables_on: assert property ($fell(srst) |-> csi_input_on && line_info_on && pipe_launch_from_csi)
      else $error("enables not on after reset");
   a_write_answers: assert property (s_wr_both |=> s_axi_bvalid)
      else $error("write response late");
endmodule
bind csi_video_pipe_front_filter front_filter_asserts u_asserts (
   .clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .pkt_hdr_valid, .pkt_line_start, .csi_input_on, .line_info_on, .pipe_launch_from_csi,
   .line_info_insert, .pkt_pass, .pkt_drop);
`default_nettype wire

// file: verilog/csi_video_pipe_front_filter.sv
// Purpose: Front-end control and virtual channel filter of one video pipe.
// Assumes: CSI-2 packet headers already parsed and synchronous to clk.
// Notes:   Registers over AXI4-Lite; unmapped addresses answer SLVERR.
//
// Functional notes
// RL1: Line-info bit gates line-start info frames.
// RL2: Port enable bit gates CSI input, resets on.
// RL3: Low filter byte keeps channels 0 to 7.
// RL4: High filter byte keeps channels 8 to 15.
// RL5: Filter bit one passes the packet.
// RL6: Filter bit zero discards the packet.
// RL7: Launch bit starts pipe from CSI port.
// RL8: Reserved bits ignore writes, keep reset value.
//
// The AXI4-Lite register port is this design's own decision.
`default_nettype none
module csi_video_pipe_front_filter (
   input  wire logic                               clk,
   input  wire logic                               srst,
   // AXI4-Lite slave
   input  wire logic [front_filter_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                               s_axi_awvalid,
   output logic                                    s_axi_awready,
   input  wire logic [31:0]                        s_axi_wdata,
   input  wire logic [3:0]                         s_axi_wstrb,
   input  wire logic                               s_axi_wvalid,
   output logic                                    s_axi_wready,
   output logic [1:0]                              s_axi_bresp,
   output logic                                    s_axi_bvalid,
   input  wire logic                               s_axi_bready,
   input  wire logic [front_filter_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                               s_axi_arvalid,
   output logic                                    s_axi_arready,
   output logic [31:0]                             s_axi_rdata,
   output logic [1:0]                              s_axi_rresp,
   output logic                                    s_axi_rvalid,
   input  wire logic                               s_axi_rready,
   // Parsed CSI-2 packet headers
   input  wire logic                               pkt_hdr_valid,
   input  wire logic [front_filter_pkg::VC_W-1:0]   pkt_hdr_vc,
   input  wire logic                               pkt_line_start,
   // Pipe controls
   output logic                                    csi_input_on,
   output logic                                    line_info_on,
   output logic                                    pipe_launch_from_csi,
   output logic                                    line_info_insert,
   output logic                                    pkt_pass,
   output logic                                    pkt_drop
);
   typedef enum logic [1:0] {W_IDLE, W_RESP} wr_state_e;

   logic [7:0]  ctrl_reg;
   logic [7:0]  filt_lo_reg;
   logic [7:0]  filt_hi_reg;
   logic [7:0]  launch_reg;
   logic [15:0] pass_cnt_reg;
   logic [15:0] drop_cnt_reg;

   logic        aw_held_reg;
   logic        w_held_reg;
   logic [front_filter_pkg::ADDR_W-1:0] aw_addr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   wr_state_e   wr_state_reg;

   logic        gate_pass;
   logic        gate_drop;
   logic        gate_enable;
   logic [15:0] keep_mask;

   // Write channel capture; address and data may come in either order
   logic aw_take;
   logic w_take;
   logic do_write;
   logic [front_filter_pkg::ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic        wr_lane0;
   logic [9:0]  wr_idx;
   logic        wr_hit;

   assign aw_take  = s_axi_awvalid && s_axi_awready;
   assign w_take   = s_axi_wvalid && s_axi_wready;
   assign wr_addr  = aw_take ? s_axi_awaddr : aw_addr_reg;
   assign wr_data  = w_take ? s_axi_wdata : wdata_reg;
   assign wr_lane0 = w_take ? s_axi_wstrb[0] : wstrb_reg[0];
   assign do_write = (wr_state_reg == W_IDLE) && (aw_held_reg || aw_take) && (w_held_reg || w_take);
   assign wr_idx   = wr_addr[front_filter_pkg::ADDR_W-1:2];
   assign wr_hit   = (wr_idx == front_filter_pkg::IDX_FRONT_PIPE_CONTROL)
                  || (wr_idx == front_filter_pkg::IDX_VC_FILTER_LOW_BYTE)
                  || (wr_idx == front_filter_pkg::IDX_VC_FILTER_HIGH_BYTE)
                  || (wr_idx == front_filter_pkg::IDX_PIPE_LAUNCH_CONTROL)
                  || (wr_idx == front_filter_pkg::IDX_PIPE_STATUS);

   always_ff @(posedge clk) begin
      if (srst) begin
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         aw_addr_reg   <= '0;
         wdata_reg     <= '0;
         wstrb_reg     <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= front_filter_pkg::RESP_OKAY;
         wr_state_reg  <= W_IDLE;
      end else begin
         case (wr_state_reg)
            W_IDLE: begin
               if (aw_take) begin
                  aw_held_reg <= 1'b1;
                  aw_addr_reg <= s_axi_awaddr;
               end
               if (w_take) begin
                  w_held_reg <= 1'b1;
                  wdata_reg  <= s_axi_wdata;
                  wstrb_reg  <= s_axi_wstrb;
               end
               s_axi_awready <= !(aw_held_reg || aw_take) && !do_write;
               s_axi_wready  <= !(w_held_reg || w_take) && !do_write;
               if (do_write) begin
                  aw_held_reg   <= 1'b0;
                  w_held_reg    <= 1'b0;
                  s_axi_awready <= 1'b0;
                  s_axi_wready  <= 1'b0;
                  s_axi_bvalid  <= 1'b1;
                  s_axi_bresp   <= wr_hit ? front_filter_pkg::RESP_OKAY : front_filter_pkg::RESP_SLVERR;
                  wr_state_reg  <= W_RESP;
               end
            end
            W_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid  <= 1'b0;
                  s_axi_awready <= 1'b1;
                  s_axi_wready  <= 1'b1;
                  wr_state_reg  <= W_IDLE;
               end
            end
            default: wr_state_reg <= W_IDLE;
         endcase
      end
   end

   // Byte registers; only the documented fields take writes
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] mask);
      merge = (old & ~mask) | (nw & mask);
   endfunction

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_reg    <= front_filter_pkg::CTRL_RESET;
         filt_lo_reg <= front_filter_pkg::FILT_RESET;
         filt_hi_reg <= front_filter_pkg::FILT_RESET;
         launch_reg  <= front_filter_pkg::LAUNCH_RESET;
      end else if (do_write && wr_lane0) begin
         case (wr_idx)
            front_filter_pkg::IDX_FRONT_PIPE_CONTROL:
               ctrl_reg <= merge(ctrl_reg, wr_data[7:0], front_filter_pkg::CTRL_WMASK);       // see RL8
            front_filter_pkg::IDX_VC_FILTER_LOW_BYTE:
               filt_lo_reg <= merge(filt_lo_reg, wr_data[7:0], front_filter_pkg::FILT_WMASK);
            front_filter_pkg::IDX_VC_FILTER_HIGH_BYTE:
               filt_hi_reg <= merge(filt_hi_reg, wr_data[7:0], front_filter_pkg::FILT_WMASK);
            front_filter_pkg::IDX_PIPE_LAUNCH_CONTROL:
               launch_reg <= merge(launch_reg, wr_data[7:0], front_filter_pkg::LAUNCH_WMASK); // see RL8
            default: ;
         endcase
      end
   end

   // Status counters; any write to the status index clears them
   always_ff @(posedge clk) begin
      if (srst || (do_write && wr_idx == front_filter_pkg::IDX_PIPE_STATUS)) begin
         pass_cnt_reg <= '0;
         drop_cnt_reg <= '0;
      end else begin
         if (gate_pass && pass_cnt_reg != 16'hFFFF) pass_cnt_reg <= pass_cnt_reg + 16'h0001;
         if (gate_drop && drop_cnt_reg != 16'hFFFF) drop_cnt_reg <= drop_cnt_reg + 16'h0001;
      end
   end

   // Read channel: one read at a time, data one cycle after address
   logic [9:0]  rd_idx;
   logic [31:0] rd_word;
   logic        rd_hit;
   assign rd_idx = s_axi_araddr[front_filter_pkg::ADDR_W-1:2];

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (rd_idx)
         front_filter_pkg::IDX_FRONT_PIPE_CONTROL:  rd_word[7:0] = ctrl_reg;
         front_filter_pkg::IDX_VC_FILTER_LOW_BYTE:  rd_word[7:0] = filt_lo_reg;
         front_filter_pkg::IDX_VC_FILTER_HIGH_BYTE: rd_word[7:0] = filt_hi_reg;
         front_filter_pkg::IDX_PIPE_LAUNCH_CONTROL: rd_word[7:0] = launch_reg;
         front_filter_pkg::IDX_PIPE_STATUS:         rd_word = {drop_cnt_reg, pass_cnt_reg};
         default:                                   rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= front_filter_pkg::RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= rd_hit ? front_filter_pkg::RESP_OKAY : front_filter_pkg::RESP_SLVERR;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // Pipe control outputs follow the registers one cycle later
   always_ff @(posedge clk) begin
      if (srst) begin
         csi_input_on         <= front_filter_pkg::CTRL_RESET[front_filter_pkg::BIT_CSI_ON];
         line_info_on         <= front_filter_pkg::CTRL_RESET[front_filter_pkg::BIT_LINE_INFO];
         pipe_launch_from_csi <= front_filter_pkg::LAUNCH_RESET[front_filter_pkg::BIT_PIPE_LAUNCH];
         line_info_insert     <= 1'b0;
      end else begin
         csi_input_on         <= ctrl_reg[front_filter_pkg::BIT_CSI_ON];                       // see RL2
         line_info_on         <= ctrl_reg[front_filter_pkg::BIT_LINE_INFO];                    // see RL1
         pipe_launch_from_csi <= launch_reg[front_filter_pkg::BIT_PIPE_LAUNCH];                // see RL7
         // Info frame only for a line start that the filter lets through
         line_info_insert     <= gate_enable && pkt_hdr_valid && pkt_line_start
                                 && ctrl_reg[front_filter_pkg::BIT_LINE_INFO]
                                 && keep_mask[pkt_hdr_vc];                                     // see RL1
      end
   end

   assign keep_mask   = {filt_hi_reg, filt_lo_reg};                                            // see RL3 see RL4
   // A disabled port or unlaunched pipe sees no packets at all
   // Gate follows the announced enables, so a header never meets a stale enable
   assign gate_enable = csi_input_on
                     && pipe_launch_from_csi;                                                 // see RL2 see RL7

   vc_packet_gate #(
      .VC_W   (front_filter_pkg::VC_W),
      .NUM_VC (front_filter_pkg::NUM_VC)
   ) u_gate (
      .clk        (clk),
      .srst       (srst),
      .keep_mask  (keep_mask),
      .enable     (gate_enable),
      .hdr_valid  (pkt_hdr_valid),
      .hdr_vc     (pkt_hdr_vc),
      .pass_pulse (gate_pass),
      .drop_pulse (gate_drop)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         pkt_pass <= 1'b0;
         pkt_drop <= 1'b0;
      end else begin
         pkt_pass <= gate_pass;
         pkt_drop <= gate_drop;
      end
   end
endmodule
`default_nettype wire

// file: verilog/vc_packet_gate.sv
// Purpose: Keep or drop one CSI-2 packet header by virtual channel.
// Assumes: Header fields arrive on the same clock; one header per valid cycle.
// Notes:   Registered output; one cycle of latency from header to decision.
`default_nettype none
module vc_packet_gate #(
   parameter int unsigned VC_W   = front_filter_pkg::VC_W,
   parameter int unsigned NUM_VC = front_filter_pkg::NUM_VC
) (
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic [NUM_VC-1:0] keep_mask,
   input  wire logic              enable,
   input  wire logic              hdr_valid,
   input  wire logic [VC_W-1:0]   hdr_vc,
   output logic                   pass_pulse,
   output logic                   drop_pulse
);
   // Every channel code must own exactly one keep bit
   if (NUM_VC != (1 << VC_W)) begin : g_bad_params
      $error("NUM_VC must equal 2**VC_W");
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pass_pulse <= 1'b0;
         drop_pulse <= 1'b0;
      end else begin
         pass_pulse <= enable && hdr_valid && keep_mask[hdr_vc];    // see RL5
         drop_pulse <= enable && hdr_valid && !keep_mask[hdr_vc];   // see RL6
      end
   end
endmodule
`default_nettype wire
